// ### pif_params.svh
// Purpose: constants of the peripheral interrupt flag block
// Assumes: included by its bare name; definitions only
// Notes:   register indices are word indices; byte address is four times the index
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH

// register word indices
`define PIF_IDX_MAIN_CTRL   10'h00B
`define PIF_IDX_FLAGS_A     10'h00C
`define PIF_IDX_FLAGS_B     10'h00D
`define PIF_IDX_STATUS      10'h00E
`define PIF_IDX_ENABLE_A    10'h106
`define PIF_IDX_ENABLE_B    10'h108

// implemented bit masks
`define PIF_MASK_A          8'h77
`define PIF_MASK_B          8'h9F
`define PIF_STICKY_A        8'h47
`define PIF_STICKY_B        8'h99

// field positions
`define PIF_BIT_GLOBAL_EN   7
`define PIF_BIT_GROUP_EN    6

// reset values and fixed vector
`define PIF_RST_REG         8'h00
`define PIF_RST_WORD        32'h0000_0000
`define PIF_IRQ_VECTOR      16'h0004

`endif

// ### pif_pkg.sv
// Purpose: types of the peripheral interrupt flag block
// Assumes: pif_params.svh holds the numbers
// Notes:   one packed struct carries all state of the top module
package pif_pkg;

  // service state of the processor interrupt path
  typedef enum logic [0:0] {
    SVC_IDLE,
    SVC_BUSY
  } pif_svc_t;

  // complete state of the top module
  typedef struct packed {
    logic [7:0]  main_ctrl;
    logic [7:0]  enable_a;
    logic [7:0]  enable_b;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    pif_svc_t    svc;
    logic        irq_req;
    logic [15:0] vector;
    logic        vector_valid;
  } pif_state_t;

endpackage

// ### pif_sticky_bits.sv
// Purpose: a row of sticky event flags with software write access
// Assumes: set pulses come from logic on the same clock
// Notes:   a set in the cycle of a clearing write wins
`timescale 1ns/10ps
module pif_sticky_bits #(
  parameter int         WIDTH = 8,
  parameter logic [7:0] MASK  = 8'hFF
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] q;                 // flag bits
  } pif_sticky_t;

  pif_sticky_t st_r;                     // registered state
  pif_sticky_t st_nxt;                   // next state
  logic [WIDTH-1:0] bit_nxt;             // per bit next value

  // one cell per flag bit, unimplemented bits held at zero
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign bit_nxt[i] = MASK[i] & (set[i] | (wr_en ? wr_data[i] : st_r.q[i]));
  end

  // next state
  always_comb begin
    st_nxt   = st_r;
    st_nxt.q = bit_nxt;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

// ### pif_level_flag.sv
// Purpose: flag that mirrors a buffer level and drops on a data access
// Assumes: level and access come from the serial port on the same clock
// Notes:   after an access the flag stays low until the level falls and rises again
`timescale 1ns/10ps
module pif_level_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  input  wire logic access,
  output logic      flag
);

  typedef struct packed {
    logic flag;                          // visible flag
    logic blocked;                       // access seen while level still high
  } pif_level_t;

  pif_level_t st_r;                      // registered state
  pif_level_t st_nxt;                    // next state

  // follow the level, hide it from the access until it drops
  always_comb begin
    st_nxt         = st_r;
    st_nxt.blocked = (st_r.blocked | access) & level;
    st_nxt.flag    = level & ~access & ~st_r.blocked;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

endmodule

// ### pif_top.sv
// Purpose: peripheral interrupt flags, enables and processor request
// Assumes: sources are on-chip logic on pclk; core acknowledges by pulse
// Notes:   APB slave with one wait state; unmapped addresses answer pslverr
//          a 1 written to a sticky flag sets it, a 0 clears it
//          a source event in the cycle of a clearing write keeps the flag
//          level flags ignore writes and follow their serial port
//          status word is read only: request, in service, pending
//          the handler saves accumulator and status; nothing is stacked here
//          global enable is not cleared on entry; nesting is blocked instead
//          enables, flags and outputs are zero after reset
`timescale 1ns/10ps
module pif_top
  import pif_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conversion_done,
  input  wire logic        pwm_period,
  input  wire logic        period_match,
  input  wire logic        wide_timer_overflow,
  input  wire logic        low_voltage,
  input  wire logic        nv_write_done,
  input  wire logic        bus_collision,
  input  wire logic        capcomp_b,
  input  wire logic        serial0_rx_full,
  input  wire logic        serial0_rx_data_read,
  input  wire logic        serial0_tx_empty,
  input  wire logic        serial0_tx_data_write,
  input  wire logic        serial1_tx_full,
  input  wire logic        serial1_tx_data_write,
  input  wire logic        serial1_rx_full,
  input  wire logic        serial1_rx_data_read,
  input  wire logic        irq_ack,
  input  wire logic        return_from_irq,
  output logic             irq_req,
  output logic      [15:0] irq_vector,
  output logic             irq_vector_valid,
  output logic             irq_in_service
);

  `include "pif_params.svh"

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  pif_state_t st_r;                      // all registered state
  pif_state_t st_nxt;                    // next value of the state

  // bus decode
  logic [9:0] word_addr;                 // word index of the access
  logic       access_ph;                 // access phase, answer not yet given
  logic       done;                      // transfer completes at this edge
  logic       wr_done;                   // completing write
  logic       hit_ctrl;                  // main control selected
  logic       hit_fa;                    // flags a selected
  logic       hit_fb;                    // flags b selected
  logic       hit_st;                    // status selected
  logic       hit_ea;                    // enable a selected
  logic       hit_eb;                    // enable b selected
  logic       mapped;                    // any register selected
  logic [7:0] rd_byte;                   // read mux result

  // flag paths and request
  logic [7:0] set_a;                     // sticky set pulses, flags a
  logic [7:0] set_b;                     // sticky set pulses, flags b
  logic [7:0] sticky_a;                  // sticky bits, flags a
  logic [7:0] sticky_b;                  // sticky bits, flags b
  logic [3:0] lvl_in;                    // buffer levels of the serial ports
  logic [3:0] lvl_acc;                   // data register accesses
  logic [3:0] lvl_flag;                  // level flags
  logic [7:0] flags_a;                   // assembled flags a
  logic [7:0] flags_b;                   // assembled flags b
  logic       pending;                   // any enabled flag
  logic       request;                   // request allowed to the core

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  // word index; byte address is four times the register index
  assign word_addr = paddr[11:2];
  assign access_ph = psel & penable & ~st_r.pready;
  assign done      = psel & penable & st_r.pready;
  assign wr_done   = done & pwrite & mapped;

  // pready comes from a register, so every transfer sees one wait;
  // a master holding penable past the answer would start a second access

  // address compare per register
  assign hit_ctrl = (word_addr == `PIF_IDX_MAIN_CTRL);
  assign hit_fa   = (word_addr == `PIF_IDX_FLAGS_A);
  assign hit_fb   = (word_addr == `PIF_IDX_FLAGS_B);
  assign hit_st   = (word_addr == `PIF_IDX_STATUS);
  assign hit_ea   = (word_addr == `PIF_IDX_ENABLE_A);
  assign hit_eb   = (word_addr == `PIF_IDX_ENABLE_B);
  assign mapped   = hit_ctrl | hit_fa | hit_fb | hit_st | hit_ea | hit_eb;

  //////////////////////////////////////////////////////////////////////////////
  // event sources

  // a source held high keeps setting its flag, so a clear written
  // while it still stands has no lasting effect
  // flags a: bit6 conversion, bit2 pwm, bit1 period match, bit0 overflow
  always_comb begin
    set_a    = 8'h00;
    set_a[6] = conversion_done;
    set_a[2] = pwm_period;
    set_a[1] = period_match;
    set_a[0] = wide_timer_overflow;
  end

  // flags b: bit7 low voltage, bit4 nv write, bit3 collision, bit0 capcomp
  always_comb begin
    set_b    = 8'h00;
    set_b[7] = low_voltage;
    set_b[4] = nv_write_done;
    set_b[3] = bus_collision;
    set_b[0] = capcomp_b;
  end

  // sticky flags, set whatever the enables say
  // mask leaves bits 7, 5, 4 and 3 to zero and the level flags
  pif_sticky_bits #(
    .WIDTH (8),
    .MASK  (`PIF_STICKY_A)
  ) u_sticky_a (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (set_a),
    .wr_en   (wr_done & hit_fa),
    .wr_data (pwdata[7:0]),
    .q       (sticky_a)
  );

  // sticky flags of the second request register
  // mask leaves bits 6, 5, 2 and 1 to zero and the level flags
  pif_sticky_bits #(
    .WIDTH (8),
    .MASK  (`PIF_STICKY_B)
  ) u_sticky_b (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (set_b),
    .wr_en   (wr_done & hit_fb),
    .wr_data (pwdata[7:0]),
    .q       (sticky_b)
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial port level flags

  // order: serial0 rx, serial0 tx, serial1 tx, serial1 rx
  // the two tx flags follow opposite levels: empty and full
  assign lvl_in  = {serial1_rx_full, serial1_tx_full, serial0_tx_empty, serial0_rx_full};
  assign lvl_acc = {serial1_rx_data_read, serial1_tx_data_write,
                    serial0_tx_data_write, serial0_rx_data_read};

  // one level cell per serial flag
  // an access drops the flag until the level falls; a second read
  // while the buffer still holds data does not raise it again
  for (genvar i = 0; i < 4; i++) begin : g_lvl
    pif_level_flag u_lvl (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (lvl_in[i]),
      .access  (lvl_acc[i]),
      .flag    (lvl_flag[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag registers as software sees them

  // level flags fill bits that the sticky masks leave at zero
  // flags a: level flags at bits 5 and 4, bits 7 and 3 read zero
  always_comb begin
    flags_a    = sticky_a & `PIF_MASK_A;
    flags_a[5] = lvl_flag[0];
    flags_a[4] = lvl_flag[1];
  end

  // flags b: level flags at bits 2 and 1, bits 6 and 5 read zero
  always_comb begin
    flags_b    = sticky_b & `PIF_MASK_B;
    flags_b[2] = lvl_flag[2];
    flags_b[1] = lvl_flag[3];
  end

  //////////////////////////////////////////////////////////////////////////////
  // request to the core

  // plain or over all sources, no ordering between them
  // enables are masked on write, so unused bits never add to pending
  assign pending = |(flags_a & st_r.enable_a) | |(flags_b & st_r.enable_b);

  // group enable, then global enable, then not while in service
  // registered below, so the request rises one cycle after its cause
  assign request = pending
                 & st_r.main_ctrl[`PIF_BIT_GROUP_EN]
                 & st_r.main_ctrl[`PIF_BIT_GLOBAL_EN]
                 & (st_r.svc == SVC_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // read mux

  // byte of the selected register, zero elsewhere
  // status: bit0 request, bit1 in service, bit2 pending
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = st_r.main_ctrl;
    end else if (hit_fa) begin
      rd_byte = flags_a;
    end else if (hit_fb) begin
      rd_byte = flags_b;
    end else if (hit_st) begin
      rd_byte = {5'b00000, pending, (st_r.svc == SVC_BUSY), st_r.irq_req};
    end else if (hit_ea) begin
      rd_byte = st_r.enable_a;
    end else if (hit_eb) begin
      rd_byte = st_r.enable_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  // bus answer, control registers and service sequence
  always_comb begin
    st_nxt              = st_r;
    st_nxt.vector_valid = 1'b0;

    // one wait state, answer raised in the cycle after the access phase opens
    // read data is captured here and stands with pready for one cycle;
    // an unmapped access answers pslverr and zero data
    st_nxt.pready = access_ph;
    if (access_ph) begin
      st_nxt.pslverr = ~mapped;
      st_nxt.prdata  = (pwrite || !mapped) ? `PIF_RST_WORD : {24'h00_0000, rd_byte};
    end else if (done) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = `PIF_RST_WORD;
    end

    // writes take effect at the completing edge only
    // main control: global enable, group enable and plain storage bits
    if (wr_done && hit_ctrl) begin
      st_nxt.main_ctrl = pwdata[7:0];
    end
    // enable registers keep unused bits at zero
    if (wr_done && hit_ea) begin
      st_nxt.enable_a = pwdata[7:0] & `PIF_MASK_A;
    end
    if (wr_done && hit_eb) begin
      st_nxt.enable_b = pwdata[7:0] & `PIF_MASK_B;
    end

    // service sequence; the handler saves accumulator and status itself
    // only a standing request is accepted; an ack without one is ignored
    // service ends only on the return pulse of the core
    // an unknown state falls back to idle
    case (st_r.svc)
      SVC_IDLE: begin
        if (irq_ack && st_r.irq_req) begin
          st_nxt.svc          = SVC_BUSY;
          st_nxt.vector       = `PIF_IRQ_VECTOR;
          st_nxt.vector_valid = 1'b1;
        end
      end
      SVC_BUSY: begin
        if (return_from_irq) begin
          st_nxt.svc = SVC_IDLE;
        end
      end
      default: begin
        st_nxt.svc = SVC_IDLE;
      end
    endcase

    // request drops at once on acceptance
    st_nxt.irq_req = request & ~(irq_ack & st_r.irq_req);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // single register for the whole state
  // reset clears every flag, enable, answer and the service state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r              <= '0;
      st_r.main_ctrl    <= `PIF_RST_REG;
      st_r.enable_a     <= `PIF_RST_REG;
      st_r.enable_b     <= `PIF_RST_REG;
      st_r.prdata       <= `PIF_RST_WORD;
      st_r.svc          <= SVC_IDLE;
      st_r.vector       <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register

  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign irq_req          = st_r.irq_req;
  assign irq_vector       = st_r.vector;
  assign irq_vector_valid = st_r.vector_valid;
  // the service state is one bit, so this is the flop itself
  assign irq_in_service   = (st_r.svc == SVC_BUSY);

endmodule

// ### pif_top_asserts.sv
// Purpose: port checks of the interrupt flag block
// Assumes: one clock, reset active low
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
`include "pif_params.svh"
module pif_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_ack,
  input wire logic        return_from_irq,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_vector_valid,
  input wire logic        irq_in_service
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // core takes a standing request
  sequence seq_accept;
    irq_req && irq_ack;
  endsequence
  // fixed vector handed over, service entered
  sequence seq_entry;
    irq_vector_valid && irq_in_service && !irq_req && irq_vector == `PIF_IRQ_VECTOR;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_accept_vector: assert property (seq_accept |=> seq_entry)
    else $error("accepted request gave no vector");
  chk_entry_cause: assert property ($rose(irq_in_service) |-> $past(irq_req) && $past(irq_ack))
    else $error("service entered without accept");
  chk_no_nesting: assert property (irq_in_service |-> !irq_req)
    else $error("request raised during service");
  chk_service_hold: assert property (irq_in_service && !return_from_irq |=> irq_in_service)
    else $error("service ended without return");
  chk_service_end: assert property (irq_in_service && return_from_irq |=> !irq_in_service)
    else $error("service kept after return");
  chk_valid_pulse: assert property (irq_vector_valid |=> !irq_vector_valid)
    else $error("vector valid longer than one cycle");
  chk_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error answer carried data");
endmodule
bind pif_top pif_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_ack(irq_ack), .return_from_irq(return_from_irq), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_vector_valid(irq_vector_valid),
  .irq_in_service(irq_in_service));

// ### pif_core_model.sv
// Purpose: processor core answering the interrupt request
// Assumes: controls come from the bench on pclk
// Notes:   acks only a raised request, after a chosen wait
`timescale 1ns/10ps
module pif_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_wait,
  input  wire logic       ret_go,
  output logic            irq_ack,
  output logic            return_from_irq
);
  logic [3:0] cnt_r;  // cycles the request has waited
  ////////////////////////////////////////////////////////////////
  // ack pulse after the wait, return pulse on command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      irq_ack <= 1'b0;
      return_from_irq <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      return_from_irq <= ret_go;  // leaves service
      if (ack_en && irq_req && !irq_ack) begin
        if (cnt_r == ack_wait) begin  // prompt or slow answer
          irq_ack <= 1'b1;
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        cnt_r <= 4'h0;  // nothing to take
      end
    end
  end
endmodule

// ### pif_top_bench.sv
// Purpose: self-checking bench of the interrupt flag block
// Assumes: core model answers requests; bench drives sources and apb
// Notes:   each scenario task judges its own outcome
`timescale 1ns/10ps
`include "pif_params.svh"
module pif_top_bench;
  localparam logic [11:0] A_MAIN = {`PIF_IDX_MAIN_CTRL, 2'b00};
  localparam logic [11:0] A_FA = {`PIF_IDX_FLAGS_A, 2'b00};
  localparam logic [11:0] A_FB = {`PIF_IDX_FLAGS_B, 2'b00};
  localparam logic [11:0] A_EA = {`PIF_IDX_ENABLE_A, 2'b00};
  localparam logic [11:0] A_EB = {`PIF_IDX_ENABLE_B, 2'b00};
  localparam logic [11:0] A_ST = {`PIF_IDX_STATUS, 2'b00};
  localparam int EPOS[8] = '{6, 2, 1, 0, 7, 4, 3, 0};  // event flag bits
  localparam int LPOS[4] = '{5, 4, 2, 1};              // level flag bits
  logic        pclk, presetn, psel, penable, pwrite, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, irq_ack, ret_irq, irq_req, vvalid, insvc, ack_en, ret_go;
  logic [15:0] vec;
  logic [7:0]  ev;        // event sources
  logic [3:0]  lv, acc;   // buffer levels and data accesses
  logic [3:0]  ack_wait;  // core answer delay
  int          num_errors, n_tests, cyc;
  pif_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conversion_done(ev[0]), .pwm_period(ev[1]), .period_match(ev[2]),
    .wide_timer_overflow(ev[3]), .low_voltage(ev[4]), .nv_write_done(ev[5]),
    .bus_collision(ev[6]), .capcomp_b(ev[7]), .serial0_rx_full(lv[0]),
    .serial0_rx_data_read(acc[0]), .serial0_tx_empty(lv[1]), .serial0_tx_data_write(acc[1]),
    .serial1_tx_full(lv[2]), .serial1_tx_data_write(acc[2]), .serial1_rx_full(lv[3]),
    .serial1_rx_data_read(acc[3]), .irq_ack(irq_ack), .return_from_irq(ret_irq),
    .irq_req(irq_req), .irq_vector(vec), .irq_vector_valid(vvalid), .irq_in_service(insvc));
  pif_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .ack_en(ack_en),
    .ack_wait(ack_wait), .ret_go(ret_go), .irq_ack(irq_ack), .return_from_irq(ret_irq));
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      test_done;
    end
  end
  task test_done;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // apb transfer: hold until pready, take data at that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      test_done;
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic er, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e, nm);
    chk(32'(perr), 32'(er), "pslverr");
  endtask
  task settle;
    repeat (4) @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    logic [11:0] ra[6];
    ra = '{A_MAIN, A_FA, A_FB, A_ST, A_EA, A_EB};
    foreach (ra[i]) rd(ra[i], 32'h0000_0000, 1'b0, "reset value");
    rd(12'h03C, 32'h0000_0000, 1'b1, "unmapped read");
  endtask
  task t_write;
    logic [11:0] wa[5];
    logic [7:0]  we[5];
    wa = '{A_MAIN, A_FA, A_FB, A_EA, A_EB};
    we = '{8'hFF, `PIF_STICKY_A, `PIF_STICKY_B, `PIF_MASK_A, `PIF_MASK_B};
    foreach (wa[i]) begin
      apb(1'b1, wa[i], 32'hFFFF_FFFF);
      rd(wa[i], {24'h00_0000, we[i]}, 1'b0, "written bits");
    end
    foreach (wa[i]) begin
      apb(1'b1, wa[i], 32'h0000_0000);
      rd(wa[i], 32'h0000_0000, 1'b0, "cleared bits");
    end
  endtask
  task t_sticky;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev <= 8'h00;
      rd(i < 4 ? A_FA : A_FB, 32'h1 << EPOS[i], 1'b0, "event flag");
      chk(32'(irq_req), 32'h0000_0000, "request while disabled");
      apb(1'b1, i < 4 ? A_FA : A_FB, 32'h0000_0000);
      rd(i < 4 ? A_FA : A_FB, 32'h0000_0000, 1'b0, "event flag cleared");
    end
  endtask
  task t_level;
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      lv[i] <= 1'b1;
      apb(1'b1, i < 2 ? A_FA : A_FB, 32'h0000_0000);
      rd(i < 2 ? A_FA : A_FB, 32'h1 << LPOS[i], 1'b0, "level flag");
      @(posedge pclk);
      acc[i] <= 1'b1;
      @(posedge pclk);
      acc <= 4'h0;
      rd(i < 2 ? A_FA : A_FB, 32'h0000_0000, 1'b0, "flag after access");
      @(posedge pclk);
      lv[i] <= 1'b0;
    end
  endtask
  task t_irq;
    int k;
    apb(1'b1, A_EA, 32'h0000_0001);
    @(posedge pclk);
    ev[3] <= 1'b1;
    @(posedge pclk);
    ev <= 8'h00;
    apb(1'b1, A_MAIN, 32'h0000_0040);
    settle;
    chk(32'(irq_req), 32'h0000_0000, "request group only");
    apb(1'b1, A_MAIN, 32'h0000_0080);
    settle;
    chk(32'(irq_req), 32'h0000_0000, "request global only");
    apb(1'b1, A_MAIN, 32'h0000_00C0);
    settle;
    chk(32'(irq_req), 32'h0000_0001, "request enabled");
    apb(1'b1, A_EA, 32'h0000_0000);
    settle;
    chk(32'(irq_req), 32'h0000_0000, "request masked");
    apb(1'b1, A_EA, 32'h0000_0001);
    ack_en <= 1'b1;
    k = 0;
    while (vvalid !== 1'b1 && k < 20) begin
      @(negedge pclk);
      k++;
    end
    if (vvalid !== 1'b1) begin
      num_errors++;
      test_done;
    end
    chk({16'h0000, vec}, {16'h0000, `PIF_IRQ_VECTOR}, "vector");
    @(posedge pclk);
    ack_en <= 1'b0;
    settle;
    chk(32'(insvc), 32'h0000_0001, "in service");
    chk(32'(irq_req), 32'h0000_0000, "request during service");
    rd(A_ST, 32'h0000_0006, 1'b0, "status in service");
    @(posedge pclk);
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    settle;
    chk(32'(insvc), 32'h0000_0000, "service after return");
    chk(32'(irq_req), 32'h0000_0001, "pending after return");
    rd(A_ST, 32'h0000_0005, 1'b0, "status pending");
    apb(1'b1, A_FA, 32'h0000_0000);
    settle;
    chk(32'(irq_req), 32'h0000_0000, "request after clear");
    apb(1'b1, A_MAIN, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ev = 8'h00;
    lv = 4'h0;
    acc = 4'h0;
    ack_en = 1'b0;
    ret_go = 1'b0;
    ack_wait = 4'h2;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_write;
    t_sticky;
    t_level;
    t_irq;
    test_done;
  end
endmodule
